// ==== rtl/jtag_ram_init_readback.sv ====
// tap-driven loader and readback port for a four-word by four-bit ram
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`default_nettype none
module jtag_ram_init_readback (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic TAP_RESET_N,
  input wire logic [7:0] TAP_INSTR_BITS,
  input wire logic TAP_SHIFT_FLAG,
  input wire logic TAP_REGISTER_CLOCK,
  input wire logic TAP_UPDATE_FLAG,
  input wire logic TAP_SERIAL_OUT_TO_CORE,
  output logic SERIAL_WORD_OUT,
  input wire logic READBACK_REQ,
  input wire logic READBACK_CLK,
  input wire logic [3:0] RAM_READ_WORD,
  output logic [3:0] READBACK_WORD,
  output logic RAM_READ_PORT_CLOCK,
  output logic RAM_WRITE_PORT_CLOCK,
  output logic RAM_WRITE_STROBE_N,
  output logic RAM_READ_STROBE_N,
  output logic [3:0] RAM_WRITE_WORD,
  output logic [1:0] RAM_WRITE_ADDR,
  output logic [1:0] RAM_READ_ADDR,
  output logic INIT_ACTIVE,
  output logic READBACK_ACTIVE
);

  // ----------------------------------------------------------------------
  // phase decode
  // ----------------------------------------------------------------------
  wire logic [7:0] tap_instruction_value;
  wire logic init_phase;
  wire logic readback_phase;
  wire logic port_clock;

  assign tap_instruction_value = TAP_INSTR_BITS;
  assign init_phase =
    (tap_instruction_value == ram_init_pkg::OP_INIT);
  assign readback_phase = READBACK_REQ &&
    (tap_instruction_value == ram_init_pkg::OP_READBACK);

  // clock mux is combinational on purpose: the ram must see the tap edge
  // itself, a resampled copy would arrive after the update state ended
  assign port_clock = readback_phase ? READBACK_CLK
                                     : !TAP_UPDATE_FLAG;
  assign RAM_READ_PORT_CLOCK = port_clock;
  assign RAM_WRITE_PORT_CLOCK = port_clock;
  assign RAM_WRITE_STROBE_N = !init_phase;
  assign RAM_READ_STROBE_N = !readback_phase;
  assign READBACK_WORD = RAM_READ_WORD;
  assign INIT_ACTIVE = init_phase;
  assign READBACK_ACTIVE = readback_phase;

  // ----------------------------------------------------------------------
  // link domain: serial-in parallel-out shift register on the tap clock
  // ----------------------------------------------------------------------
  logic [ram_init_pkg::WORD_W-1:0] shift_word;
  wire logic [ram_init_pkg::WORD_W-1:0] next_shift_word;

  // no reset here: the tap clock only runs during scans and every word
  // is fully shifted before it is committed
  assign next_shift_word = {shift_word[ram_init_pkg::WORD_W-2:0],
                            TAP_SERIAL_OUT_TO_CORE};

  always_ff @(posedge TAP_REGISTER_CLOCK) begin
    if (TAP_SHIFT_FLAG) begin
      shift_word <= next_shift_word;
    end
  end

  assign SERIAL_WORD_OUT = shift_word[ram_init_pkg::MSB_BIT];

  // ----------------------------------------------------------------------
  // crossings into the reference clock
  // ----------------------------------------------------------------------
  logic [1:0] update_sync;
  logic [1:0] rdclk_sync;
  logic update_seen;
  logic rdclk_seen;
  wire logic commit_edge;
  wire logic rdclk_edge;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      update_sync <= ram_init_pkg::SYNC_RESET;
      rdclk_sync <= ram_init_pkg::SYNC_RESET;
      update_seen <= 1'b0;
      rdclk_seen <= 1'b0;
    end else begin
      update_sync <= {update_sync[0], TAP_UPDATE_FLAG};
      rdclk_sync <= {rdclk_sync[0], READBACK_CLK};
      update_seen <= update_sync[1];
      rdclk_seen <= rdclk_sync[1];
    end
  end

  assign commit_edge = update_sync[1] && !update_seen;
  assign rdclk_edge = rdclk_sync[1] && !rdclk_seen;

  // ----------------------------------------------------------------------
  // pipeline register and address counters
  // ----------------------------------------------------------------------
  // the shift word is quiet while the update flag is high, so sampling it
  // on the synchronised rising edge is a safe multi-bit crossing
  logic [ram_init_pkg::WORD_W-1:0] write_word;
  logic [ram_init_pkg::ADDR_W-1:0] write_addr;
  logic [ram_init_pkg::ADDR_W-1:0] read_addr;
  wire logic write_step;
  wire logic read_step;
  wire logic [ram_init_pkg::ADDR_W-1:0] next_write_addr;
  wire logic [ram_init_pkg::ADDR_W-1:0] next_read_addr;

  assign write_step = commit_edge && init_phase;
  assign read_step = rdclk_edge && readback_phase;
  assign next_write_addr = write_addr + ram_init_pkg::ADDR_STEP;
  assign next_read_addr = read_addr + ram_init_pkg::ADDR_STEP;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      write_word <= ram_init_pkg::WORD_RESET;
    end else if (commit_edge) begin
      write_word <= shift_word;
    end
  end

  // the tap reset presets both counters at once, without the clock
  always_ff @(posedge REF_CLK or negedge TAP_RESET_N) begin
    if (!TAP_RESET_N) begin
      write_addr <= ram_init_pkg::ADDR_PRESET;
      read_addr <= ram_init_pkg::ADDR_PRESET;
    end else if (RESET) begin
      write_addr <= ram_init_pkg::ADDR_PRESET;
      read_addr <= ram_init_pkg::ADDR_PRESET;
    end else begin
      if (write_step) begin
        write_addr <= next_write_addr;
      end
      if (read_step) begin
        read_addr <= next_read_addr;
      end
    end
  end

  assign RAM_WRITE_WORD = write_word;
  assign RAM_WRITE_ADDR = write_addr;
  assign RAM_READ_ADDR = read_addr;

endmodule // jtag_ram_init_readback
`default_nettype wire

// ==== rtl/ram_init_pkg.sv ====
// constants shared by the tap-driven ram loader and readback block
`default_nettype none
package ram_init_pkg;
  localparam int WORD_W = 4;
  localparam int ADDR_W = 2;
  localparam int RAM_DEPTH = 4;
  localparam int INSTR_W = 8;
  localparam logic [INSTR_W-1:0] OP_INIT = 8'h22;
  localparam logic [INSTR_W-1:0] OP_READBACK = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_PRESET = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 2'h1;
  localparam logic [WORD_W-1:0] WORD_RESET = 4'h0;
  localparam int MSB_BIT = 3;
  localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage
`default_nettype wire

// ==== verif/ram_loader_monitor.sv ====
// port assertions for the tap-driven ram loader
`default_nettype none
module ram_loader_monitor (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic TAP_RESET_N,
  input wire logic [7:0] TAP_INSTR_BITS,
  input wire logic TAP_UPDATE_FLAG,
  input wire logic READBACK_REQ,
  input wire logic READBACK_CLK,
  input wire logic [3:0] RAM_READ_WORD,
  input wire logic [3:0] READBACK_WORD,
  input wire logic RAM_READ_PORT_CLOCK,
  input wire logic RAM_WRITE_PORT_CLOCK,
  input wire logic RAM_WRITE_STROBE_N,
  input wire logic RAM_READ_STROBE_N,
  input wire logic [1:0] RAM_WRITE_ADDR,
  input wire logic INIT_ACTIVE,
  input wire logic READBACK_ACTIVE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  AST_INIT: assert property (INIT_ACTIVE == (TAP_INSTR_BITS == 8'h22))
    else $error("init decode");
  AST_RB: assert property (READBACK_ACTIVE ==
    (READBACK_REQ && TAP_INSTR_BITS == 8'h23)) else $error("readback decode");
  AST_WSTB: assert property (RAM_WRITE_STROBE_N == !INIT_ACTIVE)
    else $error("write strobe");
  AST_RSTB: assert property (RAM_READ_STROBE_N == !READBACK_ACTIVE)
    else $error("read strobe");
  AST_PCLK: assert property (RAM_READ_PORT_CLOCK ==
    (READBACK_ACTIVE ? READBACK_CLK : !TAP_UPDATE_FLAG)) else $error("clk");
  AST_SAME: assert property (RAM_WRITE_PORT_CLOCK == RAM_READ_PORT_CLOCK)
    else $error("port clocks differ");
  AST_PASS: assert property (READBACK_WORD == RAM_READ_WORD)
    else $error("read word");
  AST_STEP: assert property ($changed(RAM_WRITE_ADDR) && !$past(RESET) &&
    TAP_RESET_N && $past(TAP_RESET_N) |-> $past(INIT_ACTIVE) &&
    RAM_WRITE_ADDR == $past(RAM_WRITE_ADDR) + 2'h1) else $error("addr step");
endmodule // ram_loader_monitor
bind jtag_ram_init_readback ram_loader_monitor mon (.*);
`default_nettype wire

// ==== verif/ram_model.sv ====
// four-word ram standing on the far side of the loader
`default_nettype none
module ram_model (
  input wire logic wclk,
  input wire logic rclk,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [1:0] waddr,
  input wire logic [1:0] raddr,
  input wire logic [3:0] din,
  output logic [3:0] dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] mem [4];
  // registered read: output holds between read edges, as the real array
  always @(posedge wclk) if (we_n === 1'b0) mem[waddr] <= din;
  always @(posedge rclk) if (re_n === 1'b0) dout <= mem[raddr];
endmodule // ram_model
`default_nettype wire

// ==== verif/test_jtag_ram_init_readback.sv ====
// random load of the ram through the tap path, then readback sweep
`default_nettype none
module test_jtag_ram_init_readback;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, trn = 1, sh = 0, tck = 0, upd = 0, sin = 0;
  logic req = 0, rbc = 0, so, rpc, wpc, wsn, rsn, ia, rba;
  logic [7:0] ir = 8'h00;
  logic [3:0] rw, wd, rbw, w, exp_m [4];
  logic [1:0] wa, ra;
  int n_errors = 0, n_checks = 0, a = 3;
  jtag_ram_init_readback uut (.REF_CLK(clk), .RESET(rst), .TAP_RESET_N(trn),
    .TAP_INSTR_BITS(ir), .TAP_SHIFT_FLAG(sh), .TAP_REGISTER_CLOCK(tck),
    .TAP_UPDATE_FLAG(upd), .TAP_SERIAL_OUT_TO_CORE(sin), .SERIAL_WORD_OUT(so),
    .READBACK_REQ(req), .READBACK_CLK(rbc), .RAM_READ_WORD(rw),
    .READBACK_WORD(rbw), .RAM_READ_PORT_CLOCK(rpc), .RAM_WRITE_PORT_CLOCK(wpc),
    .RAM_WRITE_STROBE_N(wsn), .RAM_READ_STROBE_N(rsn), .RAM_WRITE_WORD(wd),
    .RAM_WRITE_ADDR(wa), .RAM_READ_ADDR(ra), .INIT_ACTIVE(ia),
    .READBACK_ACTIVE(rba));
  ram_model ram (.wclk(wpc), .rclk(rpc), .we_n(wsn), .re_n(rsn), .waddr(wa),
    .raddr(ra), .din(wd), .dout(rw));
  initial forever #50 clk = ~clk;
  task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // link clock runs only inside the frame; update held 4 cycles for the sync
  task automatic load(logic [7:0] op, logic [3:0] v);
    @(posedge clk) ir <= op;
    sh <= 1;
    for (int i = 3; i >= 0; i--) begin
      sin = v[i];
      #7.5 tck = 1;
      #7.5 tck = 0;
    end
    sh = 0;
    chk("serial out", {3'h0, v[3]}, {3'h0, so});
    @(posedge clk) upd <= 1;
    repeat (4) @(posedge clk);
    upd <= 0;
    repeat (2) @(posedge clk);
    chk("write word", v, wd);
  endtask
  initial begin
    w = 4'($urandom(32'h7c15504c));
    repeat (12) @(posedge clk);
    rst <= 0;
    trn <= 0;
    @(posedge clk) trn <= 1;
    chk("preset addr", 4'h3, {2'h0, wa});
    for (int k = 0; k < 6; k++) begin
      w = 4'($urandom);
      load(k == 4 ? 8'h23 : 8'h22, w);
      if (k != 4) a = (a + 1) % 4;
      if (k != 4) exp_m[a] = w;
      chk("write addr", 4'(a), {2'h0, wa});
      chk("write strobe", {3'h0, k == 4}, {3'h0, wsn});
      chk("read strobe", 4'h1, {3'h0, rsn});
    end
    $display("init test done");
    @(posedge clk) ir <= 8'h23;
    req <= 1;
    for (int k = 0; k < 5; k++) begin
      repeat (4) @(posedge clk);
      rbc <= 1;
      repeat (4) @(posedge clk);
      rbc <= 0;
      chk("read word", exp_m[(k + 3) % 4], rbw);
      chk("read addr", 4'(k % 4), {2'h0, ra});
      chk("read strobe", 4'h0, {3'h0, rsn});
    end
    $display("readback test done");
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule // test_jtag_ram_init_readback
`default_nettype wire
